/* hw/cmsr_pkg.sv */
// Behaviour
// RULE_01: three states only: privileged handler, privileged thread, unprivileged thread.
// RULE_02: unprivileged access to protected registers is blocked and raises a fault.
// RULE_03: handler mode while an exception is active, thread mode otherwise.
// RULE_04: all sixteen core registers are 32 bits wide.
// RULE_05: low registers zero to seven reachable by every register access.
// RULE_06: high registers eight to twelve unreachable by narrow encodings.
// RULE_07: stack pointer banked into main and process pointers.
// RULE_08: process pointer used only in unprivileged thread mode; the code also uses it in privileged thread mode when control bit 1 is set.
// RULE_09: stack pointer low two bits read as zero.
// RULE_10: a subroutine call loads the link register with the return address.
// RULE_11: program counter bit zero reads as zero.
// RULE_12: result flags live in status bits 27 to 31.
// RULE_13: active exception number lives in status bits 0 to 8.
// RULE_14: execution control state lives in bits 10 to 15 and 25 to 26.
// RULE_15: status bit 24 reads one; clearing it raises a fault.
// RULE_16: global irq mask lets only nonmaskable and hard fault through.
// RULE_17: global fault mask lets only nonmaskable through.
// RULE_18: threshold blocks priorities equal to or numerically above it.
// RULE_19: threshold zero disables priority masking.
// RULE_20: control bit 0 selects thread level: 0 privileged, 1 unprivileged.
// RULE_21: control bit 1 selects main or alternate stack.
// RULE_22: software keeps stack select zero in handler mode.
// RULE_23: status views accessed singly or combined, writes limited to own fields.
package cmsr_pkg;
    localparam int unsigned AW = 8;
    // register byte offsets
    localparam logic [7:0] OFF_CORE  = 8'h00;
    localparam logic [7:0] OFF_PSR   = 8'h40;
    localparam logic [7:0] OFF_ARITH_FLAGS_STATUS  = 8'h44;
    localparam logic [7:0] OFF_ACTIVE_EXCEPTION_STATUS  = 8'h48;
    localparam logic [7:0] OFF_EXECUTION_STATE_STATUS  = 8'h4C;
    localparam logic [7:0] OFF_PRIM  = 8'h50;
    localparam logic [7:0] OFF_FLTM  = 8'h54;
    localparam logic [7:0] OFF_BPRI  = 8'h58;
    localparam logic [7:0] OFF_CTRL  = 8'h5C;
    localparam logic [7:0] OFF_MSP   = 8'h60;
    localparam logic [7:0] OFF_PSP   = 8'h64;
    // core register indices
    localparam logic [3:0] IDX_SP    = 4'hD;
    localparam logic [3:0] IDX_LR    = 4'hE;
    localparam logic [3:0] IDX_PC    = 4'hF;
    localparam logic [3:0] IDX_HIGH  = 4'h8;
    // status field positions
    localparam int unsigned ARITH_FLAGS_STATUS_LSB = 27;
    localparam int unsigned ACTIVE_EXCEPTION_STATUS_MSB = 8;
    localparam int unsigned ICI_LSB  = 10;
    localparam int unsigned IT_LSB   = 25;
    localparam int unsigned TBIT_POS = 24;
    // reset values
    localparam logic [31:0] PC_RST   = 32'h0000_0000;
    localparam logic [31:0] MSP_RST  = 32'h0000_0000;
    localparam logic [1:0]  CTRL_RST = 2'h0;
    localparam logic [8:0]  BPRI_RST = 9'h000;

    // irq request kinds
    typedef enum logic [1:0] {CMSR_IRQ_NORMAL, CMSR_IRQ_HARDF, CMSR_IRQ_NMI} cmsr_kind_t;

    typedef struct packed {
        logic             req;
        cmsr_kind_t       kind;
        logic [8:0]       prio;
    } cmsr_irq_t;

    typedef struct packed {
        logic             wr;
        logic             rd;
        logic             narrow;
        logic [AW-1:0]    addr;
        logic [31:0]      wdata;
    } cmsr_bus_t;

    typedef struct packed {
        logic [12:0][31:0] gpr;
        logic [31:0]       main_stack_pointer;
        logic [31:0]       process_stack_pointer;
        logic [31:0]       lr;
        logic [31:0]       pc;
        logic [4:0]        arith_flags_status;
        logic [8:0]        active_exception_status;
        logic [5:0]        ici;
        logic [1:0]        it;
        logic              global_irq_mask;
        logic              global_fault_mask;
        logic [8:0]        priority_threshold_mask;
        logic [1:0]        ctrl;
        logic [31:0]       rdata;
        logic              fault;
    } cmsr_state_t;
endpackage : cmsr_pkg

/* hw/cmsr_core.sv */
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module cmsr_core
    import cmsr_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        srst_i,
    input  wire cmsr_bus_t   bus_i,
    output logic [31:0]      rdata_o,
    input  wire logic        call_i,
    input  wire logic [31:0] ret_addr_i,
    input  wire logic        pc_load_i,
    input  wire logic [31:0] pc_value_i,
    input  wire logic        exc_entry_i,
    input  wire logic [8:0]  exc_num_i,
    input  wire logic        exc_return_i,
    input  wire cmsr_irq_t   irq_i,
    output logic             irq_take_o,
    output logic             fault_o,
    output logic             handler_o,
    output logic             privileged_o,
    output logic             use_psp_o
);
    cmsr_state_t st_ff;
    cmsr_state_t nxt_st;

    // combined status word from its three views
    function automatic logic [31:0] psr_word(input cmsr_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[31:ARITH_FLAGS_STATUS_LSB]       = s.arith_flags_status;          // RULE_12
        w[ACTIVE_EXCEPTION_STATUS_MSB:0]        = s.active_exception_status;          // RULE_13
        w[ICI_LSB+5:ICI_LSB] = s.ici;           // RULE_14
        w[IT_LSB+1:IT_LSB]   = s.it;            // RULE_14
        w[TBIT_POS]          = 1'b1;            // RULE_15
        return w;
    endfunction : psr_word

    // mode decode
    logic handler;
    logic priv;
    logic psp_sel;
    assign handler   = (st_ff.active_exception_status != 9'h000);               // RULE_03
    assign priv      = handler | ~st_ff.ctrl[0];             // RULE_01 RULE_20
    assign psp_sel   = ~handler & (st_ff.ctrl[0] | st_ff.ctrl[1]); // RULE_08 RULE_21

    // access classification
    logic       is_core;
    logic [3:0] cidx;
    logic       hi_blocked;
    logic       special;
    logic       mapped;
    assign is_core    = (bus_i.addr[7:6] == OFF_CORE[7:6]);
    assign cidx       = bus_i.addr[5:2];
    assign hi_blocked = is_core & bus_i.narrow & (cidx >= IDX_HIGH) & (cidx < IDX_SP); // RULE_06
    assign mapped     = is_core | (bus_i.addr >= OFF_PSR && bus_i.addr <= OFF_PSP
                        && bus_i.addr[1:0] == 2'h0);
    assign special    = mapped & ~is_core & (bus_i.addr != OFF_ARITH_FLAGS_STATUS);
    logic blocked;
    assign blocked    = special & ~priv;                     // RULE_02

    // read mux
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        if (is_core) begin
            if (cidx == IDX_SP) begin
                rd_val = psp_sel ? st_ff.process_stack_pointer : st_ff.main_stack_pointer;
                rd_val[1:0] = 2'h0;                          // RULE_09
            end else if (cidx == IDX_LR) begin
                rd_val = st_ff.lr;
            end else if (cidx == IDX_PC) begin
                rd_val = {st_ff.pc[31:1], 1'b0};             // RULE_11
            end else if (!hi_blocked) begin
                rd_val = st_ff.gpr[cidx];                    // RULE_04 RULE_05
            end
        end else begin
            case (bus_i.addr)
                OFF_PSR:  rd_val = psr_word(st_ff);          // RULE_23
                OFF_ARITH_FLAGS_STATUS: rd_val = {st_ff.arith_flags_status, 27'h0000000};
                OFF_ACTIVE_EXCEPTION_STATUS: rd_val = {23'h000000, st_ff.active_exception_status};
                OFF_EXECUTION_STATE_STATUS: rd_val = psr_word(st_ff) & 32'h0700_FC00;
                OFF_PRIM: rd_val = {31'h00000000, st_ff.global_irq_mask};
                OFF_FLTM: rd_val = {31'h00000000, st_ff.global_fault_mask};
                OFF_BPRI: rd_val = {23'h000000, st_ff.priority_threshold_mask};
                OFF_CTRL: rd_val = {30'h00000000, st_ff.ctrl};
                OFF_MSP:  rd_val = {st_ff.main_stack_pointer[31:2], 2'h0};
                OFF_PSP:  rd_val = {st_ff.process_stack_pointer[31:2], 2'h0};
                default:  rd_val = 32'h0000_0000;
            endcase
        end
        if (blocked) begin
            rd_val = 32'h0000_0000;
        end
    end

    // next state
    logic [31:0] wd;
    logic        t_clear;
    assign wd = bus_i.wdata;
    assign t_clear = bus_i.wr & ~blocked & ~wd[TBIT_POS]
                     & (bus_i.addr == OFF_PSR || bus_i.addr == OFF_EXECUTION_STATE_STATUS);
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = 32'h0000_0000;
        nxt_st.fault = 1'b0;
        // core events
        if (call_i) begin
            nxt_st.lr = ret_addr_i;                          // RULE_10
        end
        if (pc_load_i) begin
            nxt_st.pc = {pc_value_i[31:1], 1'b0};            // RULE_11
        end
        if (exc_entry_i && exc_num_i != 9'h000) begin
            nxt_st.active_exception_status = exc_num_i;                         // RULE_03
        end else if (exc_return_i) begin
            nxt_st.active_exception_status = 9'h000;                            // RULE_03
        end
        // register writes
        if (bus_i.wr && blocked) begin
            nxt_st.fault = 1'b1;                             // RULE_02
        end else if (bus_i.wr && is_core) begin
            if (cidx == IDX_SP) begin
                if (psp_sel) begin
                    nxt_st.process_stack_pointer = {wd[31:2], 2'h0};           // RULE_07 RULE_09
                end else begin
                    nxt_st.main_stack_pointer = {wd[31:2], 2'h0};           // RULE_07 RULE_09
                end
            end else if (cidx == IDX_LR) begin
                nxt_st.lr = wd;
            end else if (cidx == IDX_PC) begin
                nxt_st.pc = {wd[31:1], 1'b0};
            end else if (!hi_blocked) begin
                nxt_st.gpr[cidx] = wd;                       // RULE_05
            end
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                OFF_PSR: begin
                    nxt_st.arith_flags_status = wd[31:ARITH_FLAGS_STATUS_LSB];           // RULE_23
                    nxt_st.active_exception_status = wd[ACTIVE_EXCEPTION_STATUS_MSB:0];
                    nxt_st.ici  = wd[ICI_LSB+5:ICI_LSB];
                    nxt_st.it   = wd[IT_LSB+1:IT_LSB];
                end
                OFF_ARITH_FLAGS_STATUS: nxt_st.arith_flags_status = wd[31:ARITH_FLAGS_STATUS_LSB];     // RULE_12 RULE_23
                OFF_ACTIVE_EXCEPTION_STATUS: nxt_st.active_exception_status = wd[ACTIVE_EXCEPTION_STATUS_MSB:0];      // RULE_13 RULE_23
                OFF_EXECUTION_STATE_STATUS: begin
                    nxt_st.ici = wd[ICI_LSB+5:ICI_LSB];      // RULE_14 RULE_23
                    nxt_st.it  = wd[IT_LSB+1:IT_LSB];
                end
                OFF_PRIM: nxt_st.global_irq_mask   = wd[0];
                OFF_FLTM: nxt_st.global_fault_mask = wd[0];
                OFF_BPRI: nxt_st.priority_threshold_mask   = wd[8:0];
                OFF_CTRL: nxt_st.ctrl      = wd[1:0];        // RULE_20 RULE_21
                OFF_MSP:  nxt_st.main_stack_pointer = {wd[31:2], 2'h0};
                OFF_PSP:  nxt_st.process_stack_pointer = {wd[31:2], 2'h0};
                default:  nxt_st.ctrl = nxt_st.ctrl;
            endcase
            if (t_clear) begin
                nxt_st.fault = 1'b1;                         // RULE_15
            end
        end
        if (bus_i.rd) begin
            nxt_st.rdata = rd_val;
            if (blocked) begin
                nxt_st.fault = 1'b1;                         // RULE_02
            end
        end
    end

    // state register
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st_ff           <= '0;
            st_ff.pc        <= PC_RST;
            st_ff.main_stack_pointer       <= MSP_RST;
            st_ff.ctrl      <= CTRL_RST;
            st_ff.priority_threshold_mask   <= BPRI_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // interrupt gate
    logic prio_ok;
    assign prio_ok = (st_ff.priority_threshold_mask == 9'h000) || (irq_i.prio < st_ff.priority_threshold_mask); // RULE_18 RULE_19
    always_comb begin
        irq_take_o = 1'b0;
        if (irq_i.req) begin
            case (irq_i.kind)
                CMSR_IRQ_NMI:   irq_take_o = 1'b1;                       // RULE_17
                CMSR_IRQ_HARDF: irq_take_o = ~st_ff.global_fault_mask;           // RULE_16 RULE_17
                default: irq_take_o = ~st_ff.global_fault_mask & ~st_ff.global_irq_mask & prio_ok; // RULE_16
            endcase
        end
    end

    // outputs
    assign rdata_o      = st_ff.rdata;
    assign fault_o      = st_ff.fault;
    assign handler_o    = handler;
    assign privileged_o = priv;
    assign use_psp_o    = psp_sel;

    // checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    sequence s_unpriv_wr;
        bus_i.wr && !privileged_o && bus_i.addr == OFF_PRIM;
    endsequence
    sequence s_fault_kept;
        fault_o && $stable(st_ff.global_irq_mask);
    endsequence

    chk_handler_priv: assert property (handler_o |-> privileged_o) // RULE_01
        else $error("handler mode seen unprivileged");

    chk_blocked_fault: assert property (s_unpriv_wr |=> s_fault_kept) // RULE_02
        else $error("unprivileged write not blocked");

    chk_exc_handler: assert property (exc_entry_i && exc_num_i != 9'h000 // RULE_03
        |=> handler_o ##0 st_ff.active_exception_status == $past(exc_num_i))
        else $error("exception entry did not enter handler");

    chk_psp_thread: assert property (use_psp_o |-> !handler_o) // RULE_08
        else $error("process stack in handler mode");

    chk_psp_unpriv: assert property (!privileged_o |-> use_psp_o) // RULE_08
        else $error("unprivileged thread not on process stack");

    chk_sp_align: assert property (bus_i.rd && bus_i.addr == OFF_CORE + 8'h34 // RULE_09
        |=> rdata_o[1:0] == 2'h0)
        else $error("stack pointer unaligned");

    chk_lr_call: assert property (call_i && !bus_i.wr |=> st_ff.lr == $past(ret_addr_i)) // RULE_10
        else $error("link register not loaded");

    chk_pc_align: assert property (st_ff.pc[0] == 1'b0) // RULE_11
        else $error("program counter bit zero set");

    chk_tbit_read: assert property (bus_i.rd && bus_i.addr == OFF_PSR && privileged_o // RULE_15
        |=> rdata_o[TBIT_POS])
        else $error("status bit 24 read as zero");

    chk_tclear_fault: assert property (t_clear |=> fault_o) // RULE_15
        else $error("clearing bit 24 gave no fault");

    chk_global_irq_mask_gate: assert property (st_ff.global_irq_mask && irq_i.req // RULE_16
        && irq_i.kind == CMSR_IRQ_NORMAL |-> !irq_take_o)
        else $error("masked interrupt taken");

    chk_global_fault_mask_gate: assert property (st_ff.global_fault_mask && irq_i.req // RULE_17
        && irq_i.kind != CMSR_IRQ_NMI |-> !irq_take_o)
        else $error("fault mask let a request through");

    chk_nmi_take: assert property (irq_i.req && irq_i.kind == CMSR_IRQ_NMI |-> irq_take_o) // RULE_17
        else $error("nonmaskable interrupt refused");

    // hard fault and nonmaskable requests sit above any programmable threshold
    chk_threshold: assert property (irq_i.req && irq_i.kind == CMSR_IRQ_NORMAL // RULE_18
        && st_ff.priority_threshold_mask != 9'h000 && irq_i.prio >= st_ff.priority_threshold_mask |-> !irq_take_o)
        else $error("threshold not applied");

    chk_threshold_off: assert property (irq_i.req && irq_i.kind == CMSR_IRQ_NORMAL // RULE_19
        && st_ff.priority_threshold_mask == 9'h000 && !st_ff.global_irq_mask && !st_ff.global_fault_mask
        |-> irq_take_o)
        else $error("zero threshold still masks");

    chk_ctrl_level: assert property (!handler_o && st_ff.ctrl[0] |-> !privileged_o) // RULE_20
        else $error("control bit 0 ignored");

    // read paths: the strobe cycle, then data and fault one cycle later
    sequence s_core_rd;
        bus_i.rd && is_core;
    endsequence
    sequence s_special_rd;
        bus_i.rd && special;
    endsequence
    sequence s_refused_rd;
        fault_o && rdata_o == 32'h0000_0000;
    endsequence

    // protection of the special registers
    chk_blocked_read: assert property (s_special_rd ##0 !privileged_o // RULE_02
        |=> s_refused_rd)
        else $error("unprivileged read not refused");

    chk_priv_read: assert property (s_special_rd ##0 privileged_o // RULE_02
        |=> !fault_o)
        else $error("privileged read faulted");

    chk_ctrl_guard: assert property (bus_i.wr && !privileged_o // RULE_02
        && bus_i.addr == OFF_CTRL |=> $stable(st_ff.ctrl))
        else $error("unprivileged write changed control");

    // general purpose registers and narrow encodings
    chk_low_narrow: assert property (s_core_rd ##0 (bus_i.narrow && cidx < IDX_HIGH) // RULE_05
        |=> rdata_o == $past(st_ff.gpr[cidx]))
        else $error("low register refused to narrow read");

    chk_high_narrow: assert property (s_core_rd ##0 hi_blocked // RULE_06
        |=> rdata_o == 32'h0000_0000)
        else $error("high register seen by narrow read");

    chk_high_keep: assert property (bus_i.wr && hi_blocked // RULE_06
        |=> $stable(st_ff.gpr))
        else $error("narrow write reached a high register");

    chk_wide_high: assert property (s_core_rd ##0 (!bus_i.narrow && !hi_blocked // RULE_06
        && cidx >= IDX_HIGH && cidx < IDX_SP) |=> rdata_o == $past(st_ff.gpr[cidx]))
        else $error("high register refused to wide read");

    chk_gpr_write: assert property (bus_i.wr && is_core && cidx < IDX_SP && !hi_blocked // RULE_04
        |=> st_ff.gpr[$past(cidx)] == $past(wd))
        else $error("register write lost");

    // banked stack pointer, link register, program counter
    chk_sp_process: assert property (s_core_rd ##0 (cidx == IDX_SP && use_psp_o) // RULE_07
        |=> rdata_o == {$past(st_ff.process_stack_pointer[31:2]), 2'h0})
        else $error("process stack pointer not read");

    chk_sp_main: assert property (s_core_rd ##0 (cidx == IDX_SP && !use_psp_o) // RULE_08
        |=> rdata_o == {$past(st_ff.main_stack_pointer[31:2]), 2'h0})
        else $error("main stack pointer not read");

    chk_lr_read: assert property (s_core_rd ##0 cidx == IDX_LR // RULE_10
        |=> rdata_o == $past(st_ff.lr))
        else $error("link register read wrong");

    chk_pc_read: assert property (s_core_rd ##0 cidx == IDX_PC // RULE_11
        |=> !rdata_o[0])
        else $error("program counter read odd");

    chk_pc_load: assert property (pc_load_i && !bus_i.wr // RULE_11
        |=> st_ff.pc == {$past(pc_value_i[31:1]), 1'b0})
        else $error("program counter load lost");

    // status views
    chk_arith_flags_status_read: assert property (bus_i.rd && bus_i.addr == OFF_ARITH_FLAGS_STATUS // RULE_12
        |=> rdata_o[26:0] == 27'h0000000)
        else $error("flags view shows other fields");

    chk_arith_flags_status_write: assert property (bus_i.wr && bus_i.addr == OFF_ARITH_FLAGS_STATUS // RULE_12
        |=> st_ff.arith_flags_status == $past(wd[31:ARITH_FLAGS_STATUS_LSB]))
        else $error("flags view write lost");

    chk_arith_flags_status_own: assert property (bus_i.wr && bus_i.addr == OFF_ARITH_FLAGS_STATUS // RULE_23
        && !exc_entry_i && !exc_return_i |=> $stable(st_ff.active_exception_status) && $stable(st_ff.ici))
        else $error("flags view wrote other fields");

    chk_active_exception_status_read: assert property (bus_i.rd && bus_i.addr == OFF_ACTIVE_EXCEPTION_STATUS && privileged_o // RULE_13
        |=> rdata_o == {23'h000000, $past(st_ff.active_exception_status)})
        else $error("exception view read wrong");

    chk_execution_state_status_read: assert property (bus_i.rd && bus_i.addr == OFF_EXECUTION_STATE_STATUS && privileged_o // RULE_14
        |=> (rdata_o & 32'hF8FF_03FF) == 32'h0000_0000 && rdata_o[TBIT_POS])
        else $error("execution view read wrong");

    // mode and level
    chk_unpriv_thread: assert property (!privileged_o // RULE_01
        |-> !handler_o && st_ff.ctrl[0])
        else $error("unprivileged outside thread level");

    chk_ctrl_alt: assert property (!handler_o && st_ff.ctrl[1] // RULE_21
        |-> use_psp_o)
        else $error("alternate stack not used");

    chk_ctrl_main: assert property (!handler_o && st_ff.ctrl == 2'h0 // RULE_21
        |-> !use_psp_o)
        else $error("main stack not used");

    chk_ctrl_write: assert property (bus_i.wr && bus_i.addr == OFF_CTRL && privileged_o // RULE_20
        |=> st_ff.ctrl == $past(wd[1:0]))
        else $error("control write lost");

    chk_exc_return: assert property (exc_return_i && !exc_entry_i && !bus_i.wr // RULE_03
        |=> !handler_o)
        else $error("exception return kept handler mode");

    // interrupt gate pass cases
    chk_hardf_take: assert property (irq_i.req && irq_i.kind == CMSR_IRQ_HARDF // RULE_16
        && !st_ff.global_fault_mask |-> irq_take_o)
        else $error("hard fault refused");

    chk_threshold_pass: assert property (irq_i.req && irq_i.kind == CMSR_IRQ_NORMAL // RULE_18
        && !st_ff.global_irq_mask && !st_ff.global_fault_mask && irq_i.prio < st_ff.priority_threshold_mask |-> irq_take_o)
        else $error("request below threshold refused");
endmodule : cmsr_core

/* bench/cmsr_tb.sv */
`timescale 1ns/10ps
module tb;
    import cmsr_pkg::*;
    logic        clock_i = 1'b0;
    logic        srst_i;
    cmsr_bus_t   bus;
    cmsr_irq_t   irq;
    logic        call_i, pc_load_i, exc_entry_i, exc_return_i;
    logic [31:0] ret_addr_i, pc_value_i;
    logic [8:0]  exc_num_i;
    logic [31:0] rdata_o, rdv;
    logic        irq_take_o, fault_o, handler_o, privileged_o, use_psp_o, flt, exp;
    int          n_errors = 0;
    int          n_tests = 0;

    cmsr_core dut_u (
        .clock_i(clock_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata_o),
        .call_i(call_i), .ret_addr_i(ret_addr_i), .pc_load_i(pc_load_i),
        .pc_value_i(pc_value_i), .exc_entry_i(exc_entry_i), .exc_num_i(exc_num_i),
        .exc_return_i(exc_return_i), .irq_i(irq), .irq_take_o(irq_take_o),
        .fault_o(fault_o), .handler_o(handler_o), .privileged_o(privileged_o),
        .use_psp_o(use_psp_o)
    );

    // 100 ns clock
    always #50 clock_i = ~clock_i;

    task automatic chk32(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            n_errors++;
            $display("BAD %0t: word %h expected %h", $time, got, want);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic want);
        n_tests++;
        if (got !== want) begin
            n_errors++;
            $display("BAD %0t: flag %b expected %b", $time, got, want);
        end
    endtask : chk1

    task automatic stop_test();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // one bus cycle; read data and fault sampled in the cycle after
    task automatic acc(input logic w, input logic nar, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock_i);
        bus <= '{wr: w, rd: !w, narrow: nar, addr: a, wdata: d};
        @(posedge clock_i);
        bus <= '0;
        #1;
        rdv = rdata_o;
        flt = fault_o;
    endtask : acc

    task automatic rdchk(input logic [7:0] a, input logic nar, input logic [31:0] want,
                         input logic wflt);
        acc(1'b0, nar, a, 32'h0);
        chk32(rdv, want);
        chk1(flt, wflt);
    endtask : rdchk

    // core event pulse: 0 call, 1 pc load, 2 exception entry, 3 exception return
    task automatic ev(input int k, input logic [31:0] v);
        @(posedge clock_i);
        call_i <= (k == 0);
        pc_load_i <= (k == 1);
        exc_entry_i <= (k == 2);
        exc_return_i <= (k == 3);
        ret_addr_i <= v;
        pc_value_i <= v;
        exc_num_i <= v[8:0];
        @(posedge clock_i);
        {call_i, pc_load_i, exc_entry_i, exc_return_i} <= 4'h0;
        #1;
    endtask : ev

    // hang guard
    initial begin
        repeat (20000) @(posedge clock_i);
        n_errors++;
        $display("BAD %0t: run did not finish", $time);
        stop_test();
    end

    // main sequence
    initial begin
        static logic [8:0] pr [5] = '{9'h000, 9'h004, 9'h005, 9'h006, 9'h1FF};
        static logic [2:0] cfg [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
        srst_i = 1'b1;
        bus = '0;
        irq = '0;
        {call_i, pc_load_i, exc_entry_i, exc_return_i} = 4'h0;
        ret_addr_i = 32'h0;
        pc_value_i = 32'h0;
        exc_num_i = 9'h000;
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        #1;
        chk1(privileged_o, 1'b1);
        chk1(handler_o, 1'b0);
        chk1(use_psp_o, 1'b0);
        for (int i = 0; i < 13; i++) acc(1'b1, 1'b0, 8'(4 * i), 32'hA500_0000 | i);
        for (int i = 0; i < 13; i++) rdchk(8'(4 * i), 1'b0, 32'hA500_0000 | i, 1'b0);
        rdchk(8'h1C, 1'b1, 32'hA500_0007, 1'b0);
        rdchk(8'h20, 1'b1, 32'h0, 1'b0);
        acc(1'b1, 1'b1, 8'h24, 32'h1);
        rdchk(8'h24, 1'b0, 32'hA500_0009, 1'b0);
        acc(1'b1, 1'b0, 8'h3C, 32'h1235);
        rdchk(8'h3C, 1'b0, 32'h1234, 1'b0);
        ev(1, 32'h4567);
        rdchk(8'h3C, 1'b0, 32'h4566, 1'b0);
        ev(0, 32'h8889);
        rdchk(8'h38, 1'b0, 32'h8889, 1'b0);
        acc(1'b1, 1'b0, OFF_MSP, 32'h1003);
        acc(1'b1, 1'b0, OFF_PSP, 32'h2002);
        rdchk(8'h34, 1'b0, 32'h1000, 1'b0);
        rdchk(OFF_PSP, 1'b0, 32'h2000, 1'b0);
        acc(1'b1, 1'b0, OFF_CTRL, 32'h2);
        chk1(use_psp_o, 1'b1);
        chk1(privileged_o, 1'b1);
        rdchk(8'h34, 1'b0, 32'h2000, 1'b0);
        acc(1'b1, 1'b0, OFF_CTRL, 32'h1);
        chk1(privileged_o, 1'b0);
        chk1(use_psp_o, 1'b1);
        rdchk(OFF_PRIM, 1'b0, 32'h0, 1'b1);
        acc(1'b1, 1'b0, OFF_CTRL, 32'h0);
        chk1(flt, 1'b1);
        chk1(privileged_o, 1'b0);
        acc(1'b1, 1'b0, OFF_PRIM, 32'h1);
        chk1(flt, 1'b1);
        rdchk(8'h70, 1'b0, 32'h0, 1'b0);
        rdchk(8'h00, 1'b0, 32'hA500_0000, 1'b0);
        acc(1'b1, 1'b0, OFF_ARITH_FLAGS_STATUS, 32'hFFFF_FFFF);
        chk1(flt, 1'b0);
        ev(2, 32'h3);
        chk1(handler_o, 1'b1);
        chk1(privileged_o, 1'b1);
        chk1(use_psp_o, 1'b0);
        rdchk(OFF_ACTIVE_EXCEPTION_STATUS, 1'b0, 32'h3, 1'b0);
        rdchk(8'h34, 1'b0, 32'h1000, 1'b0);
        acc(1'b1, 1'b0, OFF_CTRL, 32'h0);
        ev(3, 32'h0);
        chk1(handler_o, 1'b0);
        rdchk(OFF_PSR, 1'b0, 32'hF900_0000, 1'b0);
        acc(1'b1, 1'b0, OFF_PSR, 32'hFFFF_FFFF);
        chk1(flt, 1'b0);
        chk1(handler_o, 1'b1);
        rdchk(OFF_PSR, 1'b0, 32'hFF00_FDFF, 1'b0);
        rdchk(OFF_EXECUTION_STATE_STATUS, 1'b0, 32'h0700_FC00, 1'b0);
        rdchk(OFF_ARITH_FLAGS_STATUS, 1'b0, 32'hF800_0000, 1'b0);
        acc(1'b1, 1'b0, OFF_EXECUTION_STATE_STATUS, 32'h0);
        chk1(flt, 1'b1);
        rdchk(OFF_PSR, 1'b0, 32'hF900_01FF, 1'b0);
        acc(1'b1, 1'b0, OFF_ACTIVE_EXCEPTION_STATUS, 32'h0);
        chk1(handler_o, 1'b0);
        // mask configurations: irq mask, fault mask, threshold of 5
        foreach (cfg[c]) begin
            acc(1'b1, 1'b0, OFF_PRIM, {31'h0, cfg[c][2]});
            acc(1'b1, 1'b0, OFF_FLTM, {31'h0, cfg[c][1]});
            acc(1'b1, 1'b0, OFF_BPRI, cfg[c][0] ? 32'h5 : 32'h0);
            rdchk(OFF_BPRI, 1'b0, cfg[c][0] ? 32'h5 : 32'h0, 1'b0);
            for (int k = 0; k < 3; k++) begin
                foreach (pr[p]) begin
                    @(posedge clock_i);
                    irq <= '{req: 1'b1, kind: cmsr_kind_t'(k), prio: pr[p]};
                    #1;
                    exp = (k == 2) || (k == 1 && !cfg[c][1]) ||
                          (k == 0 && !cfg[c][1] && !cfg[c][2] &&
                           (!cfg[c][0] || pr[p] < 9'h005));
                    chk1(irq_take_o, exp);
                end
            end
        end
        stop_test();
    end
endmodule : tb
